// ---- adc_phase_sequencer.sv ----
// conversion phase sequencer with its register slave
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module adc_phase_sequencer (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic [adc_seq_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                     awvalid,
    output logic                          awready,
    input  wire logic [31:0]              wdata,
    input  wire logic [3:0]               wstrb,
    input  wire logic                     wvalid,
    output logic                          wready,
    output logic [1:0]                    bresp,
    output logic                          bvalid,
    input  wire logic                     bready,
    input  wire logic [adc_seq_pkg::ADDR_W-1:0] araddr,
    input  wire logic                     arvalid,
    output logic                          arready,
    output logic [31:0]                   rdata,
    output logic [1:0]                    rresp,
    output logic                          rvalid,
    input  wire logic                     rready,
    input  wire logic                     conversionTrigger,
    output logic                          coreClockSourceSelect,
    output logic                          conversionStepClock,
    output logic                          converterPowerOn,
    output logic                          referenceEnable,
    output logic                          groundFromPin,
    output logic                          sampleSwitchClosed,
    output logic                          convertPhase,
    output logic                          resultTenBit,
    output logic                          conversionDone,
    output logic                          sequenceDone
);
    import adc_seq_pkg::*;

    typedef struct packed {
        phase_t              st;
        logic [7:0]          cnt;
        logic [ACC_W-1:0]    rep;
        logic [1:0]          tailCnt;
        logic                convDone;
        logic                seqDone;
        logic                doneFlag;
        logic                switchClosed;
        logic                powerOn;
        logic                refOn;
        logic                gndPin;
        logic                busy;
        logic [31:0]         cfg0;
        logic [31:0]         cfg1;
        logic                awRdy;
        logic                wRdy;
        logic                awPend;
        logic                wPend;
        logic [ADDR_W-1:0]   awAddr;
        logic [31:0]         wData;
        logic [3:0]          wStrb;
        logic                bValid;
        logic [1:0]          bResp;
        logic                arRdy;
        logic                rValid;
        logic [1:0]          rResp;
        logic [31:0]         rData;
    } seq_state_t;

    seq_state_t        q;
    seq_state_t        n;
    logic              stepTick;
    logic              startReq;
    logic              clearDone;
    logic              trig;
    logic [7:0]        target;
    logic [7:0]        cntNext;
    logic              phaseEnd;
    logic [7:0]        convLen;
    logic [31:0]       statusWord;
    logic              cfgIpo;
    logic              cfgGnd;
    logic              cfgTemp;
    logic              cfgRefFast;
    logic [TRACK_W-1:0] trackTime;
    logic [PWR_W-1:0]  powerupTime;
    logic [ACC_W-1:0]  accCount;
    phase_t            afterGap;

    // byte-lane merge of a write into a register image
    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction : mergeBytes

    // step clock from the core clock, held in phase while idle
    step_clock_divider #(
        .DIV_W    (DIV_W)
    ) u_div (
        .clk      (clk),
        .srst     (srst),
        .restart  (q.st == PH_IDLE),
        .ratio    (q.cfg0[CFG0_DIV_LSB +: DIV_W]),
        .stepTick (stepTick),
        .stepClk  (conversionStepClock)
    );

    // configuration fields in use this cycle
    assign trackTime   = q.cfg1[CFG1_TRACK_LSB +: TRACK_W];
    assign powerupTime = q.cfg1[CFG1_PWR_LSB +: PWR_W];
    assign accCount    = q.cfg0[CFG0_ACC_LSB +: ACC_W];
    assign convLen     = (q.cfg0[CFG0_BITS10_BIT] ? RESULT_BITS_SHORT : RESULT_BITS_FULL) + 8'h01;
    assign afterGap    = (trackTime != '0) ? PH_TRACK : PH_CONVERT;

    // outputs come straight from the state register
    assign awready               = q.awRdy;
    assign wready                = q.wRdy;
    assign bvalid                = q.bValid;
    assign bresp                 = q.bResp;
    assign arready               = q.arRdy;
    assign rvalid                = q.rValid;
    assign rdata                 = q.rData;
    assign rresp                 = q.rResp;
    assign coreClockSourceSelect = q.cfg0[CFG0_CLKSEL_BIT];
    assign resultTenBit          = q.cfg0[CFG0_BITS10_BIT];
    assign converterPowerOn      = q.powerOn;
    assign referenceEnable       = q.refOn;
    assign groundFromPin         = q.gndPin;
    assign sampleSwitchClosed    = q.switchClosed;
    assign convertPhase          = q.busy;
    assign conversionDone        = q.convDone;
    assign sequenceDone          = q.seqDone;

    // bus slave, phase sequencing and pin state
    always_comb begin
        n = q;
        startReq = 1'b0;
        clearDone = 1'b0;
        n.convDone = 1'b0;
        n.seqDone = 1'b0;
        statusWord = '0;
        statusWord[STAT_BUSY_BIT] = (q.st == PH_CONVERT);
        statusWord[STAT_PHASE_LSB +: 3] = q.st;
        statusWord[STAT_DONE_BIT] = q.doneFlag;
        statusWord[STAT_COUNT_LSB +: ACC_W] = q.rep;
        // write address and data are taken in either order
        if (awvalid && q.awRdy) begin
            n.awPend = 1'b1;
            n.awAddr = awaddr;
        end
        if (wvalid && q.wRdy) begin
            n.wPend = 1'b1;
            n.wData = wdata;
            n.wStrb = wstrb;
        end
        if (q.bValid && bready) begin
            n.bValid = 1'b0;
        end
        if (q.awPend && q.wPend && !q.bValid) begin
            n.awPend = 1'b0;
            n.wPend = 1'b0;
            n.bValid = 1'b1;
            n.bResp = RESP_OKAY;
            case (q.awAddr)
                CTRL_OFFSET: startReq = q.wStrb[0] && q.wData[CTRL_START_BIT];
                CFG0_OFFSET: n.cfg0 = mergeBytes(q.cfg0, q.wData, q.wStrb, CFG0_WMASK);
                CFG1_OFFSET: n.cfg1 = mergeBytes(q.cfg1, q.wData, q.wStrb, CFG1_WMASK);
                STATUS_OFFSET: clearDone = q.wStrb[0] && q.wData[STAT_DONE_BIT];
                default: n.bResp = RESP_SLVERR;
            endcase
        end
        // read answers one cycle after the address is taken
        if (q.rValid && rready) begin
            n.rValid = 1'b0;
        end
        if (arvalid && q.arRdy) begin
            n.rValid = 1'b1;
            n.rResp = RESP_OKAY;
            case (araddr)
                CTRL_OFFSET: n.rData = '0;
                CFG0_OFFSET: n.rData = q.cfg0;
                CFG1_OFFSET: n.rData = q.cfg1;
                STATUS_OFFSET: n.rData = statusWord;
                default: begin
                    n.rData = '0;
                    n.rResp = RESP_SLVERR;
                end
            endcase
        end
        n.awRdy = !n.awPend && !n.bValid;
        n.wRdy = !n.wPend && !n.bValid;
        n.arRdy = !n.rValid;

        // phase timing in whole step periods, the tail phase in core clock cycles
        trig = startReq || conversionTrigger;
        case (q.st)
            PH_POWERUP: target = powerupTime;
            PH_TRACK: target = {{(8 - TRACK_W){1'b0}}, trackTime};
            default: target = convLen;
        endcase
        cntNext = q.cnt + 8'h01;
        phaseEnd = stepTick && (cntNext == target);
        if (stepTick) begin
            n.cnt = phaseEnd ? 8'h00 : cntNext;
        end
        case (q.st)
            PH_IDLE: begin
                if (trig) begin
                    n.cnt = 8'h00;
                    n.rep = '0;
                    if (q.cfg0[CFG0_IPO_BIT] && powerupTime != '0) begin
                        n.st = PH_POWERUP;
                    end else begin
                        n.st = afterGap;
                    end
                end
            end
            PH_POWERUP: begin
                if (phaseEnd) begin
                    n.st = afterGap;
                end
            end
            PH_TRACK: begin
                if (phaseEnd) begin
                    n.st = PH_CONVERT;
                end
            end
            PH_CONVERT: begin
                if (phaseEnd) begin
                    n.convDone = 1'b1;
                    if (q.rep == accCount) begin
                        n.st = PH_TAIL;
                        n.tailCnt = '0;
                    end else begin
                        n.rep = q.rep + 1'b1;
                        n.st = afterGap;
                    end
                end
            end
            PH_TAIL: begin
                n.tailCnt = q.tailCnt + 1'b1;
                if (q.tailCnt == 2'(TAIL_CYCLES - 1)) begin
                    n.st = PH_IDLE;
                    n.seqDone = 1'b1;
                end
            end
            default: n.st = PH_IDLE;
        endcase
        // set wins over a clear in the same cycle
        if (clearDone) begin
            n.doneFlag = 1'b0;
        end
        if (n.seqDone) begin
            n.doneFlag = 1'b1;
        end

        // pin state follows the next phase and configuration
        cfgIpo = n.cfg0[CFG0_IPO_BIT];
        cfgGnd = n.cfg0[CFG0_GND_BIT];
        cfgTemp = n.cfg0[CFG0_TEMP_BIT];
        cfgRefFast = (n.cfg0[CFG0_REF_LSB +: REF_W] == REF_FAST_INTERNAL);
        n.busy = (n.st == PH_CONVERT);
        // without idle power-off the input is tracked in every phase but conversion
        n.switchClosed = (n.st == PH_TRACK) || (n.st != PH_CONVERT && !cfgIpo);
        n.powerOn = !cfgIpo || (n.st != PH_IDLE);
        n.refOn = cfgRefFast && (n.st != PH_IDLE);
        if (n.st == PH_CONVERT) begin
            n.gndPin = cfgGnd && !cfgRefFast;
        end else begin
            n.gndPin = cfgGnd && !cfgTemp;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
            q.st <= PH_IDLE;
            q.cfg0 <= CFG0_RESET;
            q.cfg1 <= CFG1_RESET;
            q.powerOn <= 1'b1;
            q.switchClosed <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // cycles spent in the current tracking phase, read only by checks
    logic [15:0] trkCyc_q;
    always_ff @(posedge clk) begin
        if (srst || q.st != PH_TRACK) begin
            trkCyc_q <= '0;
        end else begin
            trkCyc_q <= trkCyc_q + 16'h0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_trackThenConvert;
        q.st == PH_TRACK ##1 q.st == PH_CONVERT;
    endsequence

    sequence s_tailToIdle;
        q.st == PH_TAIL [*4] ##1 (q.st == PH_IDLE && q.seqDone);
    endsequence

    a_ref_off_idle: assert property (
        q.st == PH_IDLE |-> !q.refOn) else $error("fast reference on while idle");
    a_ref_held_on: assert property (
        (q.convDone && q.st != PH_TAIL && q.cfg0[CFG0_REF_LSB +: REF_W] == REF_FAST_INTERNAL)
        |-> q.refOn) else $error("fast reference dropped between conversions");
    a_gnd_pin_track: assert property (
        (q.st == PH_TRACK && q.cfg0[CFG0_GND_BIT] && !q.cfg0[CFG0_TEMP_BIT]) |-> q.gndPin)
        else $error("analog ground pin not used in tracking");
    a_gnd_temp_chip: assert property (
        (q.switchClosed && q.cfg0[CFG0_TEMP_BIT]) |-> !q.gndPin)
        else $error("temperature sensor sampled on pin ground");
    a_gnd_conv_ref: assert property (
        (q.st == PH_CONVERT && q.cfg0[CFG0_REF_LSB +: REF_W] == REF_FAST_INTERNAL) |-> !q.gndPin)
        else $error("pin ground used with fast reference");
    a_skip_powerup: assert property (
        (q.st == PH_IDLE && !q.cfg0[CFG0_IPO_BIT] && conversionTrigger) |=> q.st != PH_POWERUP)
        else $error("power-up phase without idle power-off");
    a_powerup_then: assert property (
        (q.st == PH_POWERUP ##1 q.st != PH_POWERUP) |-> q.st inside {PH_TRACK, PH_CONVERT})
        else $error("power-up not followed by tracking");
    a_no_repowerup: assert property (
        q.convDone |-> q.st != PH_POWERUP) else $error("power-up between conversions");
    a_power_down: assert property (
        (q.seqDone && q.cfg0[CFG0_IPO_BIT]) |-> (!q.powerOn && q.st == PH_IDLE))
        else $error("converter left powered after sequence");
    a_track_first: assert property (
        (q.st == PH_CONVERT && $past(q.st) != PH_CONVERT && trackTime != '0)
        |-> $past(q.st) == PH_TRACK) else $error("conversion without tracking");
    a_switch_open: assert property (
        q.st == PH_CONVERT |-> !q.switchClosed) else $error("switch closed in conversion");
    a_idle_tracks: assert property (
        (q.st == PH_IDLE && !q.cfg0[CFG0_IPO_BIT]) |-> q.switchClosed)
        else $error("switch open while idle");
    a_tail_four: assert property (
        $rose(q.st == PH_TAIL) |-> s_tailToIdle) else $error("tail not four clocks");
    a_auto_next: assert property (
        (q.convDone && q.st != PH_TAIL) |-> q.st inside {PH_TRACK, PH_CONVERT})
        else $error("later conversion waited for trigger");
    a_track_length: assert property (
        s_trackThenConvert |-> ($past(trkCyc_q) + 16'h0001 ==
        16'($past(trackTime)) * (16'($past(q.cfg0[CFG0_DIV_LSB +: DIV_W])) + 16'h0001)))
        else $error("tracking length wrong");
endmodule : adc_phase_sequencer
`default_nettype wire

// ---- adc_phase_sequencer_tb.sv ----
// self-checking bench for the conversion phase sequencer
`timescale 1ns/100ps
`default_nettype none
module adc_phase_sequencer_tb;
    import adc_seq_pkg::*;
    typedef struct {int cyc; int reps; int conv; int steps;
                    logic gT; logic gC; logic rOn; logic ipo; logic b10;} note_t;
    logic clk, srst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, conversionTrigger, clkSel, stepClk, pwrOn, refEn, gndPin;
    logic swClosed, convPh, tenBit, convDone, seqDone, sampleLost, prevConv, prevGnd, gT, gC;
    logic              rSeen, busy, prevStep;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    int                convCycles, n_mismatch, num_checks, cnt, nDone, nStep;
    note_t             seqQ[$], nt;
    logic [1:0]        wrQ[$];
    logic [33:0]       rdQ[$];

    adc_phase_sequencer dut (.clk(clk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .conversionTrigger(conversionTrigger), .coreClockSourceSelect(clkSel),
        .conversionStepClock(stepClk), .converterPowerOn(pwrOn), .referenceEnable(refEn),
        .groundFromPin(gndPin), .sampleSwitchClosed(swClosed), .convertPhase(convPh),
        .resultTenBit(tenBit), .conversionDone(convDone), .sequenceDone(seqDone));
    analog_core_model core (.clk(clk), .convertPhase(convPh), .sampleSwitchClosed(swClosed),
        .convCycles(convCycles), .sampleLost(sampleLost));

    // 40 MHz core clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [31:0] d, logic [1:0] r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        wrQ.push_back(r);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && awready) awvalid <= 1'b0;
            if (!w && wready) wvalid <= 1'b0;
            aw = aw | awready;
            w = w | wready;
        end
        while (!bvalid) @(posedge clk);
        bready <= 1'b0;
        @(posedge clk);
    endtask : axiWrite

    task automatic axiRead(input logic [ADDR_W-1:0] a, input logic [33:0] e);
        rdQ.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
        @(posedge clk);
    endtask : axiRead

    // one sequence with a random legal configuration, started by pin or by register
    task automatic runSeq(input int i);
        note_t      n;
        logic       tmp, b10;
        logic [1:0] rs;
        int         tk, acc, pwr, bits;
        rs = i[2] ? REF_FAST_INTERNAL : 2'($urandom % 3);
        tmp = 1'($urandom % 2);
        b10 = 1'($urandom % 2);
        tk = $urandom % 4;
        acc = (tk == 0) ? 0 : $urandom % 3;
        pwr = 16 + $urandom % 4;
        bits = b10 ? 10 : 12;
        n.cyc = i[3] ? -1 : 1 + (i[0] ? pwr * 3 : 0) + (acc + 1) * (tk + bits + 1) * 3 + 4;
        n.reps = acc + 1;
        n.conv = (bits + 1) * 3;
        n.gT = i[1] & !tmp;
        n.gC = i[1] & (rs != REF_FAST_INTERNAL);
        n.rOn = (rs == REF_FAST_INTERNAL);
        n.ipo = i[0];
        n.steps = (acc + 1) * (bits + 1);
        n.b10 = b10;
        axiWrite(CFG1_OFFSET, (32'(pwr) << CFG1_PWR_LSB) | 32'(tk), RESP_OKAY);
        axiWrite(CFG0_OFFSET, {11'h0, 5'(acc), 2'h0, tmp, b10, rs, i[1:0], 4'h2, 4'h0}, RESP_OKAY);
        seqQ.push_back(n);
        if (i[3]) axiWrite(CTRL_OFFSET, 32'h1, RESP_OKAY);
        else begin
            conversionTrigger <= 1'b1;
            @(posedge clk);
            conversionTrigger <= 1'b0;
        end
        do @(posedge clk); while (!seqDone);
        repeat (2) @(posedge clk);
        // idle, done flag set, index at the last conversion; then clear the flag
        axiRead(STATUS_OFFSET, {RESP_OKAY, (32'(acc) << STAT_COUNT_LSB) | (32'h1 << STAT_DONE_BIT)});
        axiWrite(STATUS_OFFSET, 32'h1 << STAT_DONE_BIT, RESP_OKAY);
    endtask : runSeq

    // watch the outputs and take the oldest note whenever a sequence ends
    always @(posedge clk) begin
        if (bvalid && bready) chk("bresp", 34'(bresp), 34'(wrQ.pop_front()));
        if (rvalid && rready) chk("rdata", {rresp, rdata}, rdQ.pop_front());
        cnt = conversionTrigger ? 0 : cnt + 1;
        nDone = nDone + int'(convDone);
        if (convPh && !prevConv) gT = prevGnd;
        busy = busy | convPh;
        if (convPh && prevConv) {gC, rSeen} = {gndPin, refEn};
        if (convPh && stepClk && !prevStep) nStep++;
        if (busy && !convPh && !prevConv && seqQ.size() > 0 && !seqQ[0].ipo)
            chk("switch", 34'(swClosed), 34'h1);
        if (seqDone) begin
            nt = seqQ.pop_front();
            if (nt.cyc >= 0) chk("cycles", 34'(cnt), 34'(nt.cyc));
            chk("conversions", 34'(nDone), 34'(nt.reps));
            chk("convert length", 34'(convCycles), 34'(nt.conv));
            chk("track ground", 34'(gT), 34'(nt.gT));
            chk("convert ground", 34'(gC), 34'(nt.gC));
            chk("reference", 34'(rSeen), 34'(nt.rOn));
            chk("power", 34'(pwrOn), 34'(!nt.ipo));
            chk("sample held", 34'(sampleLost), 34'h0);
            chk("step edges", 34'(nStep), 34'(nt.steps));
            chk("result width", 34'(tenBit), 34'(nt.b10));
            nStep = 0;
            nDone = 0;
            busy = 1'b0;
        end
        prevConv = convPh;
        prevGnd = gndPin;
        prevStep = stepClk;
    end

    // cut a hang short
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("watchdog expired");
        stop_test();
    end

    // reset, register checks, then sequences
    initial begin
        {srst, awvalid, wvalid, bready, arvalid, rready, conversionTrigger} = 7'h40;
        {awaddr, araddr, wdata, wstrb} = '0;
        {prevConv, prevGnd, busy, gT, gC, rSeen, prevStep} = '0;
        {cnt, nDone, nStep, n_mismatch, num_checks} = '0;
        void'($urandom(32'h4E68));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("clock source", 34'(clkSel), 34'h0);
        axiRead(CFG0_OFFSET, {RESP_OKAY, CFG0_RESET});
        axiRead(CFG1_OFFSET, {RESP_OKAY, CFG1_RESET});
        axiWrite(CFG0_OFFSET, 32'hFFFF_FFFF, RESP_OKAY);
        axiRead(CFG0_OFFSET, {RESP_OKAY, CFG0_WMASK});
        chk("clock source", 34'(clkSel), 34'h1);
        axiRead(4'h2, {RESP_SLVERR, 32'h0});
        axiWrite(4'h6, 32'h0, RESP_SLVERR);
        $display("test registers done");
        for (int i = 0; i < 12; i++) runSeq(i);
        $display("test sequences done");
        stop_test();
    end
endmodule : adc_phase_sequencer_tb
`default_nettype wire

// ---- adc_seq_pkg.sv ----
// package: register map, field layout and timing of the conversion sequencer
package adc_seq_pkg;
    // bus geometry
    localparam int unsigned ADDR_W            = 4;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    // register offsets
    localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 4'h0;
    localparam logic [ADDR_W-1:0] CFG0_OFFSET   = 4'h4;
    localparam logic [ADDR_W-1:0] CFG1_OFFSET   = 4'h8;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'hC;

    // control register
    localparam int unsigned CTRL_START_BIT    = 0;

    // configuration register zero
    localparam int unsigned CFG0_CLKSEL_BIT   = 0;
    localparam int unsigned CFG0_DIV_LSB      = 4;
    localparam int unsigned DIV_W             = 4;
    localparam int unsigned CFG0_IPO_BIT      = 8;
    localparam int unsigned CFG0_GND_BIT      = 9;
    localparam int unsigned CFG0_REF_LSB      = 10;
    localparam int unsigned REF_W             = 2;
    localparam int unsigned CFG0_BITS10_BIT   = 12;
    localparam int unsigned CFG0_TEMP_BIT     = 13;
    localparam int unsigned CFG0_ACC_LSB      = 16;
    localparam int unsigned ACC_W             = 5;
    localparam logic [31:0] CFG0_WMASK        = 32'h001F_3FF1;
    localparam logic [31:0] CFG0_RESET        = 32'h0000_0030;

    // configuration register one
    localparam int unsigned CFG1_TRACK_LSB    = 0;
    localparam int unsigned TRACK_W           = 6;
    localparam int unsigned CFG1_PWR_LSB      = 8;
    localparam int unsigned PWR_W             = 8;
    localparam logic [31:0] CFG1_WMASK        = 32'h0000_FF3F;
    localparam logic [31:0] CFG1_RESET        = 32'h0000_0004;

    // status register
    localparam int unsigned STAT_BUSY_BIT     = 0;
    localparam int unsigned STAT_PHASE_LSB    = 1;
    localparam int unsigned STAT_DONE_BIT     = 4;
    localparam int unsigned STAT_COUNT_LSB    = 8;

    // reference selection code of the internal fast reference
    localparam logic [REF_W-1:0] REF_FAST_INTERNAL = 2'h3;

    // result widths and timing
    localparam logic [7:0]  RESULT_BITS_FULL  = 8'h0C;
    localparam logic [7:0]  RESULT_BITS_SHORT = 8'h0A;
    localparam int unsigned TAIL_CYCLES       = 4;
    localparam int unsigned CORE_PERIOD_NS    = 25;
    localparam int unsigned STEP_MAX_MHZ      = 18;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_POWERUP,
        PH_TRACK,
        PH_CONVERT,
        PH_TAIL
    } phase_t;
endpackage : adc_seq_pkg

// ---- analog_core_model.sv ----
// behavioural model of the analog converter core behind the sample switch
`timescale 1ns/100ps
`default_nettype none
module analog_core_model (
    input  wire logic clk,
    input  wire logic convertPhase,
    input  wire logic sampleSwitchClosed,
    output var  int   convCycles,
    output var  logic sampleLost
);
    int run;

    // preset the model state
    initial begin
        run = 0;
        convCycles = 0;
        sampleLost = 1'b0;
    end

    // digitise the held voltage; a closed switch while converting spoils it
    always @(posedge clk) begin
        if (convertPhase) begin
            run <= run + 1;
            if (sampleSwitchClosed) sampleLost <= 1'b1;
        end else if (run != 0) begin
            convCycles <= run;
            run <= 0;
        end
    end
endmodule : analog_core_model
`default_nettype wire

// ---- step_clock_divider.sv ----
// step clock divider: divides the core clock by ratio plus one
`timescale 1ns/100ps
`default_nettype none
module step_clock_divider #(
    parameter int unsigned DIV_W = 4
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             restart,
    input  wire logic [DIV_W-1:0] ratio,
    output logic                  stepTick,
    output logic                  stepClk
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             clkOut;
    } div_state_t;

    div_state_t q;
    div_state_t n;

    // one tick per step period, phase held at zero while restart is high
    assign stepTick = !restart && (q.cnt == ratio);
    assign stepClk  = q.clkOut;

    // count through the period, first half of it drives the step clock high
    always_comb begin
        n = q;
        if (restart) begin
            n.cnt = '0;
        end else if (q.cnt == ratio) begin
            n.cnt = '0;
        end else begin
            n.cnt = q.cnt + 1'b1;
        end
        n.clkOut = !restart && (n.cnt <= (ratio >> 1));
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule : step_clock_divider
`default_nettype wire
